// *** charge_charge_limit_hit_flag_fault_handler.sv ***
/*
 Per-port charge limiting and fault handling for a dual port power switch.
 Assumes a byte register port driven by serial bus logic on clk_sys, and
 analog detector levels and enable pins that are asynchronous.
*/
`timescale 1ns/100ps
`include "crfh_defs.svh"
module charge_charge_limit_hit_flag_fault_handler import crfh_pkg::*; #(
    parameter int RETRY_WAIT_CYCLES = `RETRY_WAIT_CYC,
    parameter int RETRY_CHECK_CYCLES = `RETRY_CHECK_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic port1_power_enable,
    input wire logic port2_power_enable,
    input wire logic [1:0] fault_overcurrent,
    input wire logic [1:0] fault_supply_ov,
    input wire logic [1:0] fault_port_uv,
    input wire logic [1:0] fault_back_voltage,
    input wire logic [1:0] fault_discharge,
    input wire logic [1:0] keepout_port_min,
    input wire logic [1:0] keepout_other,
    input wire logic [1:0] const_current_mode,
    input wire logic thermal_stage1_limit,
    input wire logic thermal_stage2_limit,
    input wire logic [1:0] charge_tick,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    output logic port1_switch_on,
    output logic port2_switch_on,
    output logic port1_alert_n,
    output logic port2_alert_n,
    output logic [1:0] port_in_error,
    output logic [1:0] port_in_sleep
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SW = 18;
    logic [SW-1:0] async_bank;
    logic [SW-1:0] sync_bank;

    assign async_bank = {thermal_stage2_limit, thermal_stage1_limit, const_current_mode,
                         keepout_port_min, fault_discharge, fault_back_voltage, fault_port_uv,
                         fault_supply_ov, fault_overcurrent, port2_power_enable, port1_power_enable};

    sync2_bank #(.W(SW)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(async_bank),
        .sync_out(sync_bank)
    );

    wire [1:0] en_s = sync_bank[1:0];
    wire [1:0] oc_s = sync_bank[3:2];
    wire [1:0] ov_s = sync_bank[5:4];
    wire [1:0] uv_s = sync_bank[7:6];
    wire [1:0] bv_s = sync_bank[9:8];
    wire [1:0] dis_s = sync_bank[11:10];
    wire [1:0] vmin_s = sync_bank[13:12];
    wire [1:0] cc_s = sync_bank[15:14];
    wire therm1_s = sync_bank[16];
    wire therm2_s = sync_bank[17];

    // ****************************************
    // Per-port state
    // ****************************************
    logic switch_q [2];
    logic alert_n_q [2];
    logic err_q [2];
    logic sleep_q [2];
    logic [7:0] rd_port [2];

    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            localparam logic [7:0] STAT_A = (p == 0) ? `REG_P1_STATUS : `REG_P2_STATUS;
            localparam logic [7:0] CTRL_A = `REG_CTRL_BASE + 8'(p);
            localparam logic [7:0] TH_LO_A = `REG_THRESH_BASE + 8'(2 * p);
            localparam logic [7:0] TH_HI_A = `REG_THRESH_BASE + 8'(2 * p + 1);
            localparam logic [7:0] AC_LO_A = `REG_ACCUM_BASE + 8'(2 * p);
            localparam logic [7:0] AC_HI_A = `REG_ACCUM_BASE + 8'(2 * p + 1);

            accum_if acc ();

            charge_accum u_acc (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .acc(acc)
            );

            logic limit_en_reg;
            limit_action_t action_reg;
            logic latch_reg;
            logic [15:0] thresh_reg;
            logic hit_reg;
            logic hit_next;
            logic en_prev_reg;
            logic lim_alert_prev_reg;
            logic alert_lim_reg;
            logic alert_lim_next;
            logic alert_flt_reg;
            logic alert_flt_next;
            power_state_t state_reg;
            power_state_t state_next;
            logic [23:0] tmr_reg;

            // Register decode
            wire wr_ctrl = reg_wr_en && reg_addr == CTRL_A;
            wire wr_th_lo = reg_wr_en && reg_addr == TH_LO_A;
            wire wr_th_hi = reg_wr_en && reg_addr == TH_HI_A;
            wire rd_stat = reg_rd_en && reg_addr == STAT_A;
            wire restart = wr_ctrl && reg_wr_data[`CTRL_RESTART];
            wire err_clr = wr_ctrl && reg_wr_data[`CTRL_ERR_CLR];
            wire limit_off = wr_ctrl && !reg_wr_data[`CTRL_LIMIT_EN] && limit_en_reg;

            // Enable edges
            wire en_rise = en_s[p] && !en_prev_reg;
            wire en_fall = !en_s[p] && en_prev_reg;
            wire en_toggle = en_rise || en_fall;

            // Fault qualification
            wire hard_fault = oc_s[p] || ov_s[p] || uv_s[p] || bv_s[p] || dis_s[p] || therm2_s;
            wire therm1_fault = therm1_s && (cc_s[p] || en_rise);
            wire keepout_fault = vmin_s[p];
            wire fault_now = hard_fault || therm1_fault || keepout_fault;

            // Charge limit derived behaviour
            wire active = state_reg == PS_ACTIVE;
            wire lim_alert = hit_reg && (action_reg == ACT_REPORT || action_reg == ACT_REPORT_DISC);
            wire lim_block = hit_reg && (action_reg == ACT_REPORT_DISC || action_reg == ACT_DISC_SLEEP);
            wire lim_sleep = hit_reg && action_reg == ACT_DISC_SLEEP;
            wire lim_alert_rise = lim_alert && !lim_alert_prev_reg;
            wire hit_clr = restart || limit_off;
            wire hit_set = limit_en_reg && active && acc.reached && !hit_reg;

            assign acc.clear = restart || limit_off;
            assign acc.tick = charge_tick[p] && limit_en_reg && active && !hit_reg;
            assign acc.limit = thresh_reg;

            // Retry timing
            wire wait_done = tmr_reg == 24'(RETRY_WAIT_CYCLES - 1);
            wire check_done = tmr_reg == 24'(RETRY_CHECK_CYCLES - 1);
            wire want_active = en_s[p] && !lim_sleep;

            always_comb begin
                state_next = state_reg;
                case (state_reg)
                    PS_SLEEP: begin
                        if (fault_now) begin
                            state_next = PS_ERROR;
                        end else if (want_active) begin
                            state_next = PS_ACTIVE;
                        end
                    end
                    PS_ACTIVE: begin
                        if (fault_now) begin
                            state_next = PS_ERROR;
                        end else if (!want_active) begin
                            state_next = PS_SLEEP;
                        end
                    end
                    PS_ERROR: begin
                        if (latch_reg) begin
                            if (en_fall || err_clr) begin
                                state_next = PS_CHECK;
                            end
                        end else if (wait_done) begin
                            state_next = PS_CHECK;
                        end
                    end
                    PS_CHECK: begin
                        if (fault_now) begin
                            state_next = PS_ERROR;
                        end else if (latch_reg || check_done) begin
                            state_next = want_active ? PS_ACTIVE : PS_SLEEP;
                        end
                    end
                    default: begin
                        state_next = PS_SLEEP;
                    end
                endcase
            end

            wire flt_enter = state_next == PS_ERROR && (state_reg == PS_SLEEP || state_reg == PS_ACTIVE);
            wire recover = state_reg == PS_CHECK && (state_next == PS_ACTIVE || state_next == PS_SLEEP);

            assign hit_next = hit_set || (hit_reg && !hit_clr);
            assign alert_lim_next = lim_alert_rise || (alert_lim_reg && lim_alert && !rd_stat && !en_toggle);
            assign alert_flt_next = flt_enter || (alert_flt_reg && !rd_stat && !en_toggle && !recover);

            // Control registers
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    limit_en_reg <= 1'b0;
                    action_reg <= limit_action_t'(`ACTION_RESET);
                    latch_reg <= 1'b0;
                    thresh_reg <= `THRESH_RESET;
                end else begin
                    if (wr_ctrl) begin
                        limit_en_reg <= reg_wr_data[`CTRL_LIMIT_EN];
                        action_reg <= limit_action_t'(reg_wr_data[`CTRL_ACTION_LSB +: 2]);
                        latch_reg <= reg_wr_data[`CTRL_LATCH];
                    end
                    if (wr_th_lo) begin
                        thresh_reg[7:0] <= reg_wr_data;
                    end
                    if (wr_th_hi) begin
                        thresh_reg[15:8] <= reg_wr_data;
                    end
                end
            end

            // Port state and alerts
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    state_reg <= PS_SLEEP;
                    tmr_reg <= 24'h000000;
                    en_prev_reg <= 1'b0;
                    hit_reg <= 1'b0;
                    lim_alert_prev_reg <= 1'b0;
                    alert_lim_reg <= 1'b0;
                    alert_flt_reg <= 1'b0;
                end else begin
                    state_reg <= state_next;
                    tmr_reg <= (state_next != state_reg) ? 24'h000000 : tmr_reg + 24'h000001;
                    en_prev_reg <= en_s[p];
                    hit_reg <= hit_next;
                    lim_alert_prev_reg <= lim_alert;
                    alert_lim_reg <= alert_lim_next;
                    alert_flt_reg <= alert_flt_next;
                end
            end

            // Registered outputs
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    switch_q[p] <= 1'b0;
                    alert_n_q[p] <= 1'b1;
                    err_q[p] <= 1'b0;
                    sleep_q[p] <= 1'b1;
                end else begin
                    switch_q[p] <= state_next == PS_ACTIVE && !lim_block;
                    alert_n_q[p] <= !(alert_lim_next || alert_flt_next);
                    err_q[p] <= state_next == PS_ERROR || state_next == PS_CHECK;
                    sleep_q[p] <= state_next == PS_SLEEP;
                end
            end

            assign rd_port[p] = (reg_addr == STAT_A) ?
                                    {5'h00, alert_lim_reg || alert_flt_reg, hit_reg,
                                     state_reg == PS_ERROR || state_reg == PS_CHECK} :
                                (reg_addr == CTRL_A) ?
                                    {2'h0, 1'b0, latch_reg, action_reg, 1'b0, limit_en_reg} :
                                (reg_addr == TH_LO_A) ? thresh_reg[7:0] :
                                (reg_addr == TH_HI_A) ? thresh_reg[15:8] :
                                (reg_addr == AC_LO_A) ? acc.count[7:0] :
                                (reg_addr == AC_HI_A) ? acc.count[15:8] : 8'h00;
        end
    endgenerate

    // ****************************************
    // Register read port
    // ****************************************
    wire [7:0] rd_mux = rd_port[0] | rd_port[1];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_mux;
        end
    end

    assign port1_switch_on = switch_q[0];
    assign port2_switch_on = switch_q[1];
    assign port1_alert_n = alert_n_q[0];
    assign port2_alert_n = alert_n_q[1];
    assign port_in_error = {err_q[1], err_q[0]};
    assign port_in_sleep = {sleep_q[1], sleep_q[0]};

endmodule

// *** crfh_defs.svh ***
/*
 Register offsets, field positions, reset values and timing counts for the
 charge-limit and fault handler. Assumes the 10 MHz system clock.
*/
`ifndef CRFH_DEFS_SVH
`define CRFH_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define REG_P1_STATUS 8'h03
`define REG_P2_STATUS 8'h04
`define REG_CTRL_BASE 8'h10
`define REG_THRESH_BASE 8'h20
`define REG_ACCUM_BASE 8'h30

// ****************************************
// Control register fields
// ****************************************
`define CTRL_LIMIT_EN 0
`define CTRL_RESTART 1
`define CTRL_ACTION_LSB 2
`define CTRL_LATCH 4
`define CTRL_ERR_CLR 5
`define ACTION_RESET 2'h1
`define THRESH_RESET 16'hffff

// ****************************************
// Status register fields
// ****************************************
`define STAT_ERR 0
`define STAT_HIT 1
`define STAT_ALERT 2

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 10
`define RETRY_WAIT_TIME_US 20000
`define RETRY_CHECK_TIME_US 1000
`define RETRY_WAIT_CYC (`RETRY_WAIT_TIME_US * `CLK_MHZ)
`define RETRY_CHECK_CYC (`RETRY_CHECK_TIME_US * `CLK_MHZ)

`endif

// *** crfh_pkg.sv ***
/*
 Types shared by the charge-limit and fault handler modules.
 Assumes nothing of its surroundings.
*/
package crfh_pkg;

    typedef enum logic [1:0] {
        ACT_REPORT = 2'h0,
        ACT_REPORT_DISC = 2'h1,
        ACT_DISC_SLEEP = 2'h2,
        ACT_IGNORE = 2'h3
    } limit_action_t;

    typedef enum logic [1:0] {
        PS_SLEEP = 2'h0,
        PS_ACTIVE = 2'h1,
        PS_ERROR = 2'h2,
        PS_CHECK = 2'h3
    } power_state_t;

endpackage

// *** accum_if.sv ***
/*
 Carrier between the port logic and its charge accumulator.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface accum_if;
    logic clear;
    logic tick;
    logic [15:0] limit;
    logic [15:0] count;
    logic reached;

    modport owner (output clear, output tick, output limit, input count, input reached);
    modport counter (input clear, input tick, input limit, output count, output reached);
endinterface

// *** sync2_bank.sv ***
/*
 Two flip-flop synchroniser for a bank of asynchronous levels.
 Assumes the inputs are slow levels, not pulses.
*/
`timescale 1ns/100ps
module sync2_bank #(parameter int W = 1) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// *** charge_accum.sv ***
/*
 Saturating accumulated-charge counter for one port, with threshold compare.
 Assumes ticks come from the current monitor on the same clock.
*/
`timescale 1ns/100ps
module charge_accum (
    input wire logic clk_sys,
    input wire logic nrst,
    accum_if.counter acc
);
    logic [15:0] count_reg;
    logic [15:0] count_next;

    assign count_next = acc.clear ? 16'h0000 :
                        (acc.tick && count_reg != 16'hffff) ? count_reg + 16'h0001 : count_reg;
    assign acc.count = count_reg;
    assign acc.reached = count_reg >= acc.limit;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 16'h0000;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// *** crfh_checker_properties.sv ***
/*
 Concurrent checks on the ports of the charge-limit and fault handler.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/100ps
module crfh_checker import crfh_pkg::*; #(
    parameter int RETRY_WAIT_CYCLES = 8,
    parameter int RETRY_CHECK_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [1:0] fault_overcurrent,
    input wire logic [1:0] keepout_port_min,
    input wire logic thermal_stage2_limit,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic port1_switch_on,
    input wire logic port2_switch_on,
    input wire logic port1_alert_n,
    input wire logic [1:0] port_in_error,
    input wire logic [1:0] port_in_sleep
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic unmapped;
    assign unmapped = !(reg_addr inside {8'h03, 8'h04, 8'h10, 8'h11, [8'h20:8'h23], [8'h30:8'h33]});
    sequence s_oc_held;
        $rose(fault_overcurrent[0]) ##1 fault_overcurrent[0] [*3];
    endsequence
    sequence s_km_held;
        $rose(keepout_port_min[1]) ##1 keepout_port_min[1] [*3];
    endsequence
    sequence s_hot_held;
        $rose(thermal_stage2_limit) ##1 thermal_stage2_limit [*3];
    endsequence
    property p_oc_error;
        s_oc_held |-> port_in_error[0];
    endproperty
    a_oc_error: assert property (p_oc_error) else $error("overcurrent did not enter error");
    property p_km_error;
        s_km_held |-> port_in_error[1] && port2_switch_on == 1'b0;
    endproperty
    a_km_error: assert property (p_km_error) else $error("port minimum keep-out not a fault");
    property p_hot_error;
        s_hot_held |-> port_in_error == 2'b11;
    endproperty
    a_hot_error: assert property (p_hot_error) else $error("stage two heat missed a port");
    property p_err_sw1;
        port_in_error[0] |-> !port1_switch_on;
    endproperty
    a_err_sw1: assert property (p_err_sw1) else $error("port1 switch closed in error");
    property p_err_sw2;
        port_in_error[1] |-> !port2_switch_on;
    endproperty
    a_err_sw2: assert property (p_err_sw2) else $error("port2 switch closed in error");
    property p_err_alert;
        $rose(port_in_error[0]) |-> !port1_alert_n;
    endproperty
    a_err_alert: assert property (p_err_alert) else $error("error entered without alert");
    property p_sleep_sw;
        port_in_sleep[0] |-> !port1_switch_on;
    endproperty
    a_sleep_sw: assert property (p_sleep_sw) else $error("switch closed in sleep");
    property p_rd_alert;
        reg_rd_en && reg_addr == 8'h03 && port_in_error[0] && !port1_alert_n |=> port1_alert_n && port_in_error[0];
    endproperty
    a_rd_alert: assert property (p_rd_alert) else $error("status read did not drop alert");
    property p_rd_unmapped;
        reg_rd_en && unmapped |=> reg_rd_data == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_hold;
        !reg_rd_en |=> $stable(reg_rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule
bind charge_charge_limit_hit_flag_fault_handler crfh_checker #(.RETRY_WAIT_CYCLES(RETRY_WAIT_CYCLES),
    .RETRY_CHECK_CYCLES(RETRY_CHECK_CYCLES)) crfh_checker_inst (.clk_sys(clk_sys), .nrst(nrst),
    .fault_overcurrent(fault_overcurrent), .keepout_port_min(keepout_port_min),
    .thermal_stage2_limit(thermal_stage2_limit), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .port1_switch_on(port1_switch_on), .port2_switch_on(port2_switch_on),
    .port1_alert_n(port1_alert_n), .port_in_error(port_in_error), .port_in_sleep(port_in_sleep));

// *** host_model.sv ***
/*
 Host controller model: register port cycles and enable pins.
 Assumes the register port of the handler on the same clock.
*/
`timescale 1ns/100ps
module host_model (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rd_data,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_wr_data,
    output logic port1_power_enable,
    output logic port2_power_enable
);
    // ****************************************
    // Bus cycles
    // ****************************************
    initial begin
        {reg_addr, reg_wr_en, reg_rd_en, reg_wr_data} = 18'h0;
        {port1_power_enable, port2_power_enable} = 2'b00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_wr_data <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        #1;
        d = reg_rd_data;
    endtask
    task automatic set_en(input logic [1:0] e);
        @(posedge clk_sys);
        port1_power_enable <= e[0];
        port2_power_enable <= e[1];
    endtask
    task automatic clear_err(input logic [7:0] ctrl, output logic [7:0] st);
        st = 8'h01;
        for (int i = 0; i < 4 && st[0]; i++) begin
            wr(8'h10, ctrl | 8'h20);
            repeat (4) @(posedge clk_sys);
            rd(8'h03, st);
        end
    endtask
endmodule

// *** tb_charge_charge_limit_hit_flag_fault_handler.sv ***
/*
 Self-checking testbench for the charge-limit and fault handler.
 Assumes the host model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
module tb_charge_charge_limit_hit_flag_fault_handler import crfh_pkg::*; ;
    // ****************************************
    // Bench
    // ****************************************
    localparam int RW = 8;
    localparam int RC = 4;
    logic clk_sys, nrst, reg_wr_en, reg_rd_en, en1, en2, thermal1, thermal2, sw1, sw2, a1_n, a2_n;
    logic [1:0] flt [6];
    logic [1:0] keepout_other, const_current_mode, charge_tick, in_err, in_sleep, m;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, v, st_bus;
    int err_count, cmp_count, cnt;
    assign st_bus = {in_sleep, in_err, a2_n, a1_n, sw2, sw1};
    host_model host_model_inst (.clk_sys(clk_sys), .reg_rd_data(reg_rd_data), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data),
        .port1_power_enable(en1), .port2_power_enable(en2));
    charge_charge_limit_hit_flag_fault_handler #(.RETRY_WAIT_CYCLES(RW), .RETRY_CHECK_CYCLES(RC))
        charge_charge_limit_hit_flag_fault_handler_inst (.clk_sys(clk_sys), .nrst(nrst), .port1_power_enable(en1),
        .port2_power_enable(en2), .fault_overcurrent(flt[0]), .fault_supply_ov(flt[1]),
        .fault_port_uv(flt[2]), .fault_back_voltage(flt[3]), .fault_discharge(flt[4]),
        .keepout_port_min(flt[5]), .keepout_other(keepout_other), .const_current_mode(const_current_mode),
        .thermal_stage1_limit(thermal1), .thermal_stage2_limit(thermal2), .charge_tick(charge_tick),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .port1_switch_on(sw1), .port2_switch_on(sw2), .port1_alert_n(a1_n),
        .port2_alert_n(a2_n), .port_in_error(in_err), .port_in_sleep(in_sleep));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host_model_inst.rd(a, v);
        check(v, exp);
    endtask
    task automatic outs(input logic [7:0] exp);
        repeat (4) @(posedge clk_sys);
        #1;
        check(st_bus, exp);
    endtask
    task automatic ctl(input logic [7:0] d, input logic [7:0] exp);
        host_model_inst.wr(8'h10, d);
        outs(exp);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            charge_tick <= 2'b01;
            @(posedge clk_sys);
            charge_tick <= 2'b00;
        end
    endtask
    task automatic wait_clr();
        cnt = 0;
        while (in_err !== 2'b00 && cnt < 100) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        complete_run();
    end
    initial begin
        nrst = 1'b0;
        for (int i = 0; i < 6; i++) flt[i] = 2'b00;
        {keepout_other, const_current_mode, charge_tick, thermal1, thermal2} = 8'h00;
        err_count = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        outs(8'hcc);
        rdc(8'h10, 8'h04);
        rdc(8'h11, 8'h04);
        rdc(8'h21, 8'hff);
        rdc(8'h32, 8'h00);
        rdc(8'h55, 8'h00);
        host_model_inst.wr(8'h03, 8'hff);
        rdc(8'h03, 8'h00);
        host_model_inst.set_en(2'b01);
        outs(8'h8d);
        host_model_inst.set_en(2'b11);
        outs(8'h0f);
        host_model_inst.wr(8'h20, 8'h03);
        host_model_inst.wr(8'h21, 8'h00);
        ctl(8'h01, 8'h0f);
        tick(3);
        outs(8'h0b);
        rdc(8'h30, 8'h03);
        ctl(8'h0d, 8'h0f);
        ctl(8'h01, 8'h0b);
        ctl(8'h05, 8'h0a);
        ctl(8'h09, 8'h4e);
        ctl(8'h05, 8'h0a);
        ctl(8'h0d, 8'h0f);
        ctl(8'h09, 8'h4e);
        ctl(8'h01, 8'h0b);
        ctl(8'h00, 8'h0f);
        rdc(8'h30, 8'h00);
        rdc(8'h03, 8'h00);
        ctl(8'h01, 8'h0f);
        tick(2);
        rdc(8'h30, 8'h02);
        ctl(8'h03, 8'h0f);
        rdc(8'h10, 8'h01);
        rdc(8'h30, 8'h00);
        tick(1);
        rdc(8'h30, 8'h01);
        tick(2);
        outs(8'h0b);
        ctl(8'h03, 8'h0f);
        rdc(8'h03, 8'h00);
        ctl(8'h00, 8'h0f);
        for (int i = 0; i < 6; i++) begin
            m = i[0] ? 2'b10 : 2'b01;
            @(posedge clk_sys);
            flt[i] <= m;
            outs({2'b00, m, ~m, ~m});
            @(posedge clk_sys);
            flt[i] <= 2'b00;
            wait_clr();
            check({7'h0, cnt >= RW && cnt <= RW + RC + 8}, 8'h01);
            outs(8'h0f);
        end
        @(posedge clk_sys);
        keepout_other <= 2'b11;
        thermal1 <= 1'b1;
        outs(8'h0f);
        @(posedge clk_sys);
        const_current_mode <= 2'b01;
        outs(8'h1a);
        @(posedge clk_sys);
        {const_current_mode, thermal1} <= 3'h0;
        wait_clr();
        outs(8'h0f);
        @(posedge clk_sys);
        thermal2 <= 1'b1;
        outs(8'h30);
        @(posedge clk_sys);
        thermal2 <= 1'b0;
        wait_clr();
        outs(8'h0f);
        ctl(8'h14, 8'h0f);
        @(posedge clk_sys);
        flt[0] <= 2'b01;
        outs(8'h1a);
        @(posedge clk_sys);
        flt[0] <= 2'b00;
        repeat (30) @(posedge clk_sys);
        outs(8'h1a);
        rdc(8'h03, 8'h05);
        outs(8'h1e);
        host_model_inst.clear_err(8'h14, v);
        check(v, 8'h00);
        outs(8'h0f);
        @(posedge clk_sys);
        flt[0] <= 2'b01;
        repeat (20) @(posedge clk_sys);
        outs(8'h1a);
        host_model_inst.clear_err(8'h14, v);
        check({7'h0, v[0]}, 8'h01);
        @(posedge clk_sys);
        flt[0] <= 2'b00;
        host_model_inst.set_en(2'b10);
        outs(8'h4e);
        host_model_inst.set_en(2'b11);
        outs(8'h0f);
        @(posedge clk_sys);
        flt[0] <= 2'b01;
        outs(8'h1a);
        host_model_inst.set_en(2'b10);
        outs(8'h1e);
        @(posedge clk_sys);
        flt[0] <= 2'b00;
        host_model_inst.clear_err(8'h14, v);
        check(v, 8'h00);
        host_model_inst.set_en(2'b11);
        outs(8'h0f);
        complete_run();
    end
endmodule
